// file: bench/mcs_flash_model.sv
`default_nettype none
module mcs_flash_model (
    input wire logic clk_i,
    input wire mcs_pkg::mcs_flash_req_t flash_i,
    output logic [15:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:8191];
    logic [15:0] last_reg = 16'h0;
    always_ff @(posedge clk_i) begin
        if (flash_i.req) begin
            last_reg <= data_o;
        end
    end
    // Idle bus shows the inverted last word, so a late sample never matches
    always_comb begin
        if (flash_i.req) begin
            data_o = {mem[flash_i.addr[12:0]], mem[flash_i.addr[12:0] + 13'h1]};
        end else begin
            data_o = ~last_reg;
        end
    end
endmodule : mcs_flash_model
`default_nettype wire

// file: bench/mcs_scanner_bench.sv
`default_nettype none
module mcs_scanner_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic fuse_en = 1'b0;
    logic [1:0] fuse_rng = 2'h0;
    logic sleep = 1'b0;
    logic irq = 1'b0;
    logic stall, hold, nmi;
    mcs_pkg::mcs_flash_req_t flash;
    logic [15:0] fdata;
    logic [31:0] rd;
    int err_total = 0;
    int checks = 0;
    int cyc_n = 0;
    int last_chg = 0;
    int sleep_fetch = 0;
    logic pace_on = 1'b1;
    logic [15:0] last_adr = 16'h0;

    always #20 clk_i = ~clk_i;

    mcs_scanner uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .reset_scan_en_fuse_i(fuse_en), .reset_scan_range_fuse_i(fuse_rng), .loader_region_end_fuse_i(8'h01),
        .code_region_end_fuse_i(8'h02), .cpu_sleep_i(sleep), .irq_pending_i(irq), .cpu_stall_o(stall),
        .irq_hold_o(hold), .nmi_o(nmi), .flash_o(flash), .flash_data_i(fdata));
    mcs_flash_model flash_m (.clk_i(clk_i), .flash_i(flash), .data_o(fdata));

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    function automatic logic [15:0] crc_of(input int n);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ flash_m.mem[i][b]) ? 16'h1021 : 16'h0);
            end
        end
        return c;
    endfunction : crc_of

    // Fetch spacing, and no fetch while the CPU sleeps
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (flash.req === 1'b1 && flash.addr !== last_adr) begin
            if (pace_on && last_chg != 0) begin
                chk("fetch_gap", 32'd3, 32'(cyc_n - last_chg));
            end
            last_chg <= cyc_n;
            last_adr <= flash.addr;
        end
        if (sleep && flash.req === 1'b1) begin
            sleep_fetch <= sleep_fetch + 1;
        end
    end

    // ----------------------------------------
    // Bus, memory and scan tasks
    // ----------------------------------------
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        chk("ack", 32'h1, 32'(ack_o));
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic fill(input int n, input bit good);
        logic [15:0] c;
        for (int i = 0; i < n - 2; i++) begin
            flash_m.mem[i] = 8'($urandom);
        end
        c = crc_of(n - 2);
        if (!good) begin
            c = c ^ 16'h0100;
        end
        flash_m.mem[n - 2] = c[15:8];
        flash_m.mem[n - 1] = c[7:0];
    endtask : fill

    task automatic wait_idle();
        int k;
        k = 0;
        rd = 32'h1;
        while (rd[0] === 1'b1 && k < 6000) begin
            wb(1'b0, 4'h8, 32'h0, rd);
            k++;
        end
        chk("busy_end", 32'h0, 32'(rd[0]));
    endtask : wait_idle

    task automatic run(input logic [1:0] src, input int n, input bit good, input bit arm);
        fill(n, good);
        wb(1'b1, 4'h4, {30'h0, src}, rd);
        last_chg = 0;
        wb(1'b1, 4'h0, {30'h0, arm, 1'b1}, rd);
        chk("stall_delay", 32'h0, 32'(stall));
        repeat (5) @(posedge clk_i);
        chk("stall_busy", 32'h1, 32'(stall));
        chk("nmi_early", 32'h0, 32'(nmi));
        wait_idle();
        chk("ok", 32'(good), 32'(rd[1]));
        chk("stall_idle", 32'h0, 32'(stall));
    endtask : run

    task automatic do_reset(input bit fen, input int n, input bit good);
        fill(n, good);
        fuse_en <= fen;
        fuse_rng <= 2'h2;
        rst_i <= 1'b1;
        last_chg = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (900) @(posedge clk_i);
    endtask : do_reset

    initial begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        conclude();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(26));
        do_reset(1'b0, 256, 1'b1);
        chk("stall_rst", 32'h0, 32'(stall));
        wb(1'b0, 4'h8, 32'h0, rd);
        chk("status_rst", 32'h2, rd & 32'h3);
        run(2'h2, 256, 1'b1, 1'b0);
        run(2'h1, 512, 1'b1, 1'b0);
        run(2'h0, 8192, 1'b1, 1'b0);
        wb(1'b1, 4'h0, 32'h0, rd);
        wb(1'b0, 4'h0, 32'h0, rd);
        chk("en_stays", 32'h1, 32'(rd[0]));
        run(2'h2, 256, 1'b0, 1'b0);
        chk("nmi_unarmed", 32'h0, 32'(nmi));
        pace_on <= 1'b0;
        sleep <= 1'b1;
        wb(1'b1, 4'h0, 32'h1, rd);
        repeat (60) @(posedge clk_i);
        chk("sleep_fetch", 32'h0, 32'(sleep_fetch));
        irq <= 1'b1;
        sleep <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("irq_hold", 32'h1, 32'(hold));
        wait_idle();
        chk("irq_free", 32'h0, 32'(hold));
        irq <= 1'b0;
        pace_on <= 1'b1;
        run(2'h2, 256, 1'b0, 1'b1);
        chk("nmi", 32'h1, 32'(nmi));
        wb(1'b1, 4'h4, 32'h1, rd);
        wb(1'b0, 4'h4, 32'h0, rd);
        chk("src_locked", 32'h2, 32'(rd[1:0]));
        repeat (50) @(posedge clk_i);
        chk("nmi_held", 32'h1, 32'(nmi));
        do_reset(1'b1, 256, 1'b1);
        chk("nmi_cleared", 32'h0, 32'(nmi));
        chk("rs_run", 32'h0, 32'(stall));
        wb(1'b0, 4'h0, 32'h0, rd);
        chk("rs_en", 32'h1, 32'(rd[0]));
        chk("rs_arm_clr", 32'h0, 32'(rd[1]));
        wb(1'b0, 4'h4, 32'h0, rd);
        chk("rs_src", 32'h2, 32'(rd[1:0]));
        wb(1'b0, 4'h8, 32'h0, rd);
        chk("rs_ok", 32'h2, rd & 32'h3);
        do_reset(1'b1, 256, 1'b0);
        chk("rs_hang", 32'h1, 32'(stall));
        wb(1'b0, 4'h8, 32'h0, rd);
        chk("rs_fail", 32'h0, rd & 32'h3);
        wb(1'b0, 4'h0, 32'h0, rd);
        chk("rs_fail_en", 32'h1, 32'(rd[0]));
        conclude();
    end
endmodule : mcs_scanner_bench
`default_nettype wire

// file: rtl/mcs_pkg.sv
// How it works
// - Checksum is a 16-bit CCITT code, polynomial x^16 + x^12 + x^5 + 1.
// - Running checksum starts at all ones at the start of every check.
// - Bytes go in from the section's first byte, MSB first, one update each.
// - Result is compared with the stored reference; match passes, mismatch fails.
// - Scan range is whole flash, loader only, or loader plus code.
// - Select range then enable; scan begins three cycles later, CPU still runs.
// - Fuse-enabled reset scan runs before CPU starts; failure blocks execution.
// - Passing reset scan releases CPU with enable, range and pass shown.
// - Failing reset scan keeps CPU hung; enable and range shown, pass reads zero.
// - Stall mode takes flash priority and stalls the CPU until done.
// - One 16-bit word is fetched every third clock, reset scans included.
// - A failed check clears the pass flag.
// - Writing one arms the failure interrupt unless busy; only system reset disarms it.
// - Failure while armed raises a non-maskable request held until system reset.
// - The failure request ignores the CPU global interrupt enable.
// - Scanning halts while the CPU sleeps and resumes on wake.
// - Sleep during the start delay defers the scan start until wake.
// - A waking interrupt handler runs only after the scan has finished.
// - Range codes: whole flash 0, loader plus code 1, loader only 2, 3 reserved.
// - Writing zero to enable does nothing; it stays one; writing one restarts unless busy or after a failure request, when it is ignored.
// - Mode and range writes are ignored while busy or after a failure request.
`default_nettype none
package mcs_pkg;
    localparam logic [15:0] MCS_CRC_POLY = 16'h1021;
    localparam logic [15:0] MCS_CRC_INIT = 16'hffff;
    localparam int MCS_START_DLY = 3;
    localparam int MCS_FETCH_PER = 3;
    localparam int MCS_AW = 16;
    localparam int MCS_PAGE_SHIFT = 8;
    localparam logic [MCS_AW-1:0] MCS_FLASH_BYTES = 16'h2000;
    // Wishbone word offsets (byte address)
    localparam logic [3:0] MCS_OFF_CTRLA = 4'h0;
    localparam logic [3:0] MCS_OFF_CTRLB = 4'h4;
    localparam logic [3:0] MCS_OFF_STATUS = 4'h8;
    // Field positions
    localparam int MCS_A_EN = 0;
    localparam int MCS_A_ARM = 1;
    localparam int MCS_A_RST = 7;
    localparam int MCS_B_SRC = 0;
    localparam int MCS_B_MODE = 4;
    localparam int MCS_S_BUSY = 0;
    localparam int MCS_S_OK = 1;
    localparam logic [1:0] MCS_SRC_FLASH = 2'h0;
    localparam logic [1:0] MCS_SRC_LOADER_AND_CODE_RANGE = 2'h1;
    localparam logic [1:0] MCS_SRC_BOOT = 2'h2;
    localparam logic [1:0] MCS_MODE_PRIO = 2'h0;
    localparam logic [1:0] MCS_MODE_RESET_SCAN = 2'h1;
    localparam logic MCS_OK_RESET = 1'b1;
    localparam int MCS_DLY_W = 2;
    localparam logic [MCS_DLY_W-1:0] MCS_DLY_LAST = 2'(MCS_START_DLY - 1);
    localparam logic [MCS_DLY_W-1:0] MCS_FETCH_LAST = 2'(MCS_FETCH_PER - 1);

    typedef enum logic [1:0] {
        MCS_ST_IDLE,
        MCS_ST_DELAY,
        MCS_ST_SCAN,
        MCS_ST_CMP
    } mcs_state_t;

    typedef struct packed {
        logic req;
        logic [MCS_AW-1:0] addr;
    } mcs_flash_req_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] src;
    } mcs_cfg_t;
endpackage : mcs_pkg
`default_nettype wire

// file: rtl/mcs_scanner.sv
// The implementer's own choices: the Wishbone register port and the register addresses.
`default_nettype none
module mcs_scanner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Reset-scan fuses sampled on the first enabled clock after reset; region-end fuses read at each scan start
    input wire logic reset_scan_en_fuse_i,
    input wire logic [1:0] reset_scan_range_fuse_i,
    input wire logic [7:0] loader_region_end_fuse_i,
    input wire logic [7:0] code_region_end_fuse_i,
    // CPU side
    input wire logic cpu_sleep_i,
    input wire logic irq_pending_i,
    output logic cpu_stall_o,
    output logic irq_hold_o,
    output logic nmi_o,
    // Flash side
    output mcs_pkg::mcs_flash_req_t flash_o,
    input wire logic [15:0] flash_data_i
);
    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ b[i]) ? ((r << 1) ^ mcs_pkg::MCS_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_byte

    function automatic logic [mcs_pkg::MCS_AW-1:0] section_end(input logic [1:0] s,
            input logic [7:0] lf, input logic [7:0] cf);
        logic [mcs_pkg::MCS_AW-1:0] e;
        e = mcs_pkg::MCS_FLASH_BYTES;
        case (s)
            mcs_pkg::MCS_SRC_LOADER_AND_CODE_RANGE: e = {cf, 8'h00};
            mcs_pkg::MCS_SRC_BOOT: e = {lf, 8'h00};
            default: e = mcs_pkg::MCS_FLASH_BYTES;
        endcase
        return e;
    endfunction : section_end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    mcs_pkg::mcs_state_t state_reg;
    logic en_reg;
    logic arm_reg;
    logic ok_reg;
    logic busy_reg;
    logic nmi_reg;
    logic boot_reg;
    logic boot_fail_reg;
    logic fuse_taken_reg;
    mcs_pkg::mcs_cfg_t cfg_reg;
    logic [mcs_pkg::MCS_DLY_W-1:0] cnt_reg;
    logic [15:0] crc_reg;
    logic [mcs_pkg::MCS_AW-1:0] addr_reg;
    logic [mcs_pkg::MCS_AW-1:0] end_reg;
    logic [15:0] ref_reg;
    logic fetch_pend_reg;

    logic wr_a;
    logic wr_b;
    logic start_cmd;
    logic soft_rst;
    logic run;
    logic fetch_now;
    logic [15:0] crc_next;
    logic last_word;
    logic fail_now;

    assign wr_a = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == mcs_pkg::MCS_OFF_CTRLA && !nmi_reg;
    assign wr_b = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == mcs_pkg::MCS_OFF_CTRLB;
    assign start_cmd = wr_a && dat_i[mcs_pkg::MCS_A_EN] && !busy_reg;
    assign soft_rst = wr_a && dat_i[mcs_pkg::MCS_A_RST] && !(arm_reg && busy_reg);
    // Sleep freezes the scan engine only; bus stays alive
    assign run = ce_i && !cpu_sleep_i;
    assign fetch_now = state_reg == mcs_pkg::MCS_ST_SCAN && cnt_reg == mcs_pkg::MCS_FETCH_LAST;
    assign last_word = addr_reg + 16'(2) >= end_reg;
    assign crc_next = crc_byte(crc_byte(crc_reg, flash_data_i[15:8]), flash_data_i[7:0]);
    // A check fails only at its final compare, so an old failure never fires again
    assign fail_now = state_reg == mcs_pkg::MCS_ST_CMP && run && !soft_rst && ref_reg != crc_reg;

    // ----------------------------------------------------------------
    // Fuse capture and reset-time scan
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fuse_taken_reg <= 1'b0;
            boot_reg <= 1'b0;
            boot_fail_reg <= 1'b0;
        end else if (ce_i) begin
            if (!fuse_taken_reg) begin
                fuse_taken_reg <= 1'b1;
                boot_reg <= reset_scan_en_fuse_i;
            end else if (boot_reg && state_reg == mcs_pkg::MCS_ST_CMP && run) begin
                boot_reg <= 1'b0;
                boot_fail_reg <= ref_reg != crc_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg <= 1'b0;
            cfg_reg <= '0;
        end else if (ce_i) begin
            if (!fuse_taken_reg && reset_scan_en_fuse_i) begin
                en_reg <= 1'b1;
                cfg_reg.src <= reset_scan_range_fuse_i;
                cfg_reg.mode <= mcs_pkg::MCS_MODE_RESET_SCAN;
            end else if (soft_rst) begin
                en_reg <= 1'b0;
                cfg_reg <= '0;
            end else begin
                if (start_cmd) begin
                    en_reg <= 1'b1;
                end
                if (wr_b && !busy_reg && !nmi_reg && state_reg == mcs_pkg::MCS_ST_IDLE) begin
                    cfg_reg.src <= dat_i[mcs_pkg::MCS_B_SRC +: 2];
                    cfg_reg.mode <= dat_i[mcs_pkg::MCS_B_MODE +: 2];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arm_reg <= 1'b0;
        end else if (ce_i && wr_a && dat_i[mcs_pkg::MCS_A_ARM] && !busy_reg) begin
            arm_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Scan engine
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= mcs_pkg::MCS_ST_IDLE;
            cnt_reg <= '0;
            crc_reg <= mcs_pkg::MCS_CRC_INIT;
            addr_reg <= '0;
            end_reg <= '0;
            ref_reg <= '0;
            busy_reg <= 1'b0;
            ok_reg <= mcs_pkg::MCS_OK_RESET;
            fetch_pend_reg <= 1'b0;
        end else if (ce_i) begin
            if (!fuse_taken_reg && reset_scan_en_fuse_i) begin
                state_reg <= mcs_pkg::MCS_ST_SCAN;
                busy_reg <= 1'b1;
                crc_reg <= mcs_pkg::MCS_CRC_INIT;
                addr_reg <= '0;
                cnt_reg <= '0;
                end_reg <= section_end(reset_scan_range_fuse_i, loader_region_end_fuse_i,
                    code_region_end_fuse_i);
            end else if (soft_rst) begin
                state_reg <= mcs_pkg::MCS_ST_IDLE;
                busy_reg <= 1'b0;
                ok_reg <= mcs_pkg::MCS_OK_RESET;
                fetch_pend_reg <= 1'b0;
            end else if (start_cmd) begin
                state_reg <= mcs_pkg::MCS_ST_DELAY;
                cnt_reg <= '0;
            end else if (run) begin
                fetch_pend_reg <= fetch_now;
                case (state_reg)
                    mcs_pkg::MCS_ST_IDLE: begin
                    end
                    mcs_pkg::MCS_ST_DELAY: begin
                        cnt_reg <= cnt_reg + 2'(1);
                        if (cnt_reg == mcs_pkg::MCS_DLY_LAST - 2'(1)) begin
                            state_reg <= mcs_pkg::MCS_ST_SCAN;
                            busy_reg <= 1'b1;
                            cnt_reg <= '0;
                            crc_reg <= mcs_pkg::MCS_CRC_INIT;
                            addr_reg <= '0;
                            end_reg <= section_end(cfg_reg.src, loader_region_end_fuse_i,
                                code_region_end_fuse_i);
                        end
                    end
                    mcs_pkg::MCS_ST_SCAN: begin
                        // One word every third cycle
                        cnt_reg <= fetch_now ? '0 : cnt_reg + 2'(1);
                        if (fetch_now) begin
                            if (last_word) begin
                                ref_reg <= flash_data_i;
                                state_reg <= mcs_pkg::MCS_ST_CMP;
                            end else begin
                                crc_reg <= crc_next;
                                addr_reg <= addr_reg + 16'(2);
                            end
                        end
                    end
                    mcs_pkg::MCS_ST_CMP: begin
                        ok_reg <= ref_reg == crc_reg;
                        busy_reg <= 1'b0;
                        state_reg <= mcs_pkg::MCS_ST_IDLE;
                    end
                    default: state_reg <= mcs_pkg::MCS_ST_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs to CPU and flash
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_reg <= 1'b0;
        end else if (arm_reg && fail_now) begin
            // Arming after an earlier unarmed failure stays quiet until the next failure
            nmi_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_stall_o <= 1'b1;
            irq_hold_o <= 1'b0;
            nmi_o <= 1'b0;
            flash_o <= '0;
        end else if (ce_i) begin
            // Stall while scanning; a failed reset scan hangs the CPU for good
            cpu_stall_o <= !fuse_taken_reg || boot_reg || boot_fail_reg ||
                state_reg == mcs_pkg::MCS_ST_SCAN || state_reg == mcs_pkg::MCS_ST_CMP;
            irq_hold_o <= irq_pending_i && state_reg != mcs_pkg::MCS_ST_IDLE;
            nmi_o <= nmi_reg;
            flash_o.req <= state_reg == mcs_pkg::MCS_ST_SCAN;
            flash_o.addr <= addr_reg;
        end
    end

    // ----------------------------------------------------------------
    // Wishbone slave: ack one cycle after request
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else if (ce_i) begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= '0;
            case (adr_i)
                mcs_pkg::MCS_OFF_CTRLA: begin
                    dat_o[mcs_pkg::MCS_A_EN] <= en_reg;
                    dat_o[mcs_pkg::MCS_A_ARM] <= arm_reg;
                end
                mcs_pkg::MCS_OFF_CTRLB: begin
                    dat_o[mcs_pkg::MCS_B_SRC +: 2] <= cfg_reg.src;
                    dat_o[mcs_pkg::MCS_B_MODE +: 2] <= cfg_reg.mode;
                end
                mcs_pkg::MCS_OFF_STATUS: begin
                    dat_o[mcs_pkg::MCS_S_BUSY] <= busy_reg;
                    dat_o[mcs_pkg::MCS_S_OK] <= ok_reg && !busy_reg;
                end
                default: dat_o <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_enable_write;
        start_cmd && ce_i && !soft_rst;
    endsequence

    AST_START_DELAY: assert property (@(posedge clk_i) disable iff (rst_i)
        s_enable_write ##1 (run && !start_cmd && !soft_rst)[*2] |=> busy_reg)
        else $error("Scan did not start three cycles after enable");
    AST_NO_BUSY_IN_DELAY: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == mcs_pkg::MCS_ST_DELAY && cpu_sleep_i && !start_cmd && !soft_rst |=> !busy_reg)
        else $error("Scan started while asleep");
    AST_FETCH_PACE: assert property (@(posedge clk_i) disable iff (rst_i)
        fetch_now && run && !last_word && !start_cmd && !soft_rst && fuse_taken_reg
        |=> !fetch_now ##1 !fetch_now)
        else $error("Fetch pacing wrong");
    AST_CRC_INIT: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy_reg) |-> crc_reg == mcs_pkg::MCS_CRC_INIT)
        else $error("Checksum not preset");
    AST_COMPARE: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == mcs_pkg::MCS_ST_CMP && run && !soft_rst && !start_cmd |=> ok_reg == (ref_reg == $past(crc_reg)))
        else $error("Compare result wrong");
    AST_ARM_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
        arm_reg |=> arm_reg)
        else $error("Arm bit cleared");
    AST_NMI_RAISE: assert property (@(posedge clk_i) disable iff (rst_i)
        arm_reg && fail_now ##1 ce_i |=> nmi_o)
        else $error("Failure request not raised");
    AST_NMI_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        nmi_o |=> nmi_o)
        else $error("Failure request dropped");
    AST_STALL: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && state_reg == mcs_pkg::MCS_ST_SCAN |=> cpu_stall_o && flash_o.req)
        else $error("CPU not stalled during scan");
    AST_CFG_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_reg && !soft_rst |=> $stable(cfg_reg))
        else $error("Config changed while busy");

    // ----------------------------------------------------------------
    // Assertions: scan set-up, address stepping and CPU hand-back
    // ----------------------------------------------------------------
    sequence s_scan_entry;
        $rose(busy_reg);
    endsequence

    sequence s_word_step;
        fetch_now && run && !last_word && !soft_rst && !start_cmd && fuse_taken_reg;
    endsequence

    sequence s_boot_verdict;
        boot_reg && state_reg == mcs_pkg::MCS_ST_CMP && run && fuse_taken_reg;
    endsequence

    // The section end is checked per range code so a decode slip shows up by name
    AST_ADDR_START: assert property (@(posedge clk_i) disable iff (rst_i)
        s_scan_entry |-> addr_reg == '0)
        else $error("Scan did not begin at the first byte");
    AST_END_BOOT: assert property (@(posedge clk_i) disable iff (rst_i)
        s_scan_entry |-> cfg_reg.src != mcs_pkg::MCS_SRC_BOOT || end_reg == (16'(loader_region_end_fuse_i) << 8))
        else $error("Loader range has the wrong end");
    AST_END_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_scan_entry |-> cfg_reg.src != mcs_pkg::MCS_SRC_LOADER_AND_CODE_RANGE || end_reg == (16'(code_region_end_fuse_i) << 8))
        else $error("Loader and code range has the wrong end");
    AST_END_FLASH: assert property (@(posedge clk_i) disable iff (rst_i)
        s_scan_entry |-> cfg_reg.src == mcs_pkg::MCS_SRC_BOOT || cfg_reg.src == mcs_pkg::MCS_SRC_LOADER_AND_CODE_RANGE
            || end_reg == mcs_pkg::MCS_FLASH_BYTES)
        else $error("Whole-flash range has the wrong end");
    AST_ADDR_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
        s_word_step |=> addr_reg == $past(addr_reg) + 16'(2))
        else $error("Word address did not step by one word");
    AST_FAIL_CLEARS_OK: assert property (@(posedge clk_i) disable iff (rst_i)
        fail_now |=> !ok_reg)
        else $error("Pass flag not cleared on failure");
    AST_BUSY_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == mcs_pkg::MCS_ST_CMP && run && !soft_rst |=> !busy_reg)
        else $error("Busy still high after the compare");

    // A hung CPU must stay stalled; a passed reset scan must let it go
    AST_DELAY_NO_STALL: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == mcs_pkg::MCS_ST_DELAY && ce_i && fuse_taken_reg && !boot_reg && !boot_fail_reg
        |=> !cpu_stall_o)
        else $error("CPU stalled during the start delay");
    AST_BOOT_HANG: assert property (@(posedge clk_i) disable iff (rst_i)
        boot_fail_reg && ce_i |=> cpu_stall_o)
        else $error("CPU released after a failed reset scan");
    AST_BOOT_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_boot_verdict ##1 (ce_i && !boot_fail_reg) |=> !cpu_stall_o)
        else $error("CPU not released after a passed reset scan");
    AST_IRQ_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && irq_pending_i && state_reg != mcs_pkg::MCS_ST_IDLE |=> irq_hold_o)
        else $error("Interrupt handler not held during scan");
    AST_EN_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
        en_reg && !soft_rst |=> en_reg)
        else $error("Enable bit dropped without a block reset");
endmodule : mcs_scanner
`default_nettype wire
